/* File: verilog/sq_sequencer.sv */
// microprogram address sequencer with its program memory
// assumes an apb master on pclk and external test and reset pins

module sq_sequencer (
    input  wire logic        pclk,      // system clock
    input  wire logic        presetn,   // async reset, active low
    input  wire logic        ce,        // clock enable, freezes all
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb write
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic      [31:0] prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error, unmapped
    input  wire logic [7:0]  test_in,   // test pins
    input  wire logic        seq_rst_n, // sequencer reset pin
    output logic      [15:0] ctl_out,   // control outputs
    output logic             ctl_hi_oe  // enable of ctl_out 15:8
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [35:0]      pipe;     // pipeline register
        logic [8:0]       pc;       // program counter
        logic [8:0]       count_register;     // count_register
        logic [4:0]       sp;       // stack pointer
        logic [16:0][8:0] stack;    // stack words
        logic             match;    // match_flag
        logic [7:0]       t_s1;     // test pin sync stage 1
        logic [7:0]       t_s2;     // test pin sync stage 2
        logic [7:0]       t_s3;     // test pin sync stage 3
        logic [7:0]       t_f;      // filtered test pins
        logic [7:0]       t_r;      // optional test register
        logic             r_s1;     // reset pin sync stage 1
        logic             r_s2;     // reset pin sync stage 2
        logic             r_s3;     // reset pin sync stage 3
        logic             r_f;      // filtered reset pin
        logic             r_r;      // optional reset register
        logic             run;      // sequencer running
        logic             expose;   // address_expose_option
        logic             rsync;    // reset pin registered
        logic [7:0]       tsync;    // test pins registered
        logic [8:0]       mem_addr; // program load address
        logic [31:0]      mem_lo;   // staged low word
        logic             pready;   // apb ready
        logic [31:0]      prdata;   // apb read data
        logic             pslverr;  // apb error
        logic [15:0]      ctl_out;  // control outputs
        logic             ctl_hi_oe; // upper output enable
    } sq_state_type;

    sq_state_type   st;        // registered state
    sq_state_type   next_st;   // next state
    logic [35:0]    prog_mem [512]; // program memory
    logic           mem_we;    // program word commit
    logic [8:0]     next_addr; // next address mux output
    logic [35:0]    mem_word;  // word at next address

    // ==========================================================
    // helpers
    // circular stack pointer step forward
    function automatic logic [4:0] sq_inc17(input logic [4:0] p);
        sq_inc17 = (p == sq_pkg::STACK_LAST) ? 5'h00 : p + 5'h01;
    endfunction : sq_inc17

    // circular stack pointer step back
    function automatic logic [4:0] sq_dec17(input logic [4:0] p);
        sq_dec17 = (p == 5'h00) ? sq_pkg::STACK_LAST : p - 5'h01;
    endfunction : sq_dec17

    // ==========================================================
    // decode signals
    logic [4:0]  op;        // opcode
    logic        condition_polarity;       // condition_polarity
    logic [3:0]  sel;       // condition select
    logic [8:0]  data;      // immediate data
    logic [7:0]  tst;       // test inputs as used
    logic        rst_act;   // sequencer reset active
    logic [7:0]  tm;        // masked tests
    logic [8:0]  bv_tm;     // masked branch value
    logic [8:0]  stack_top; // top of stack
    logic        zero;      // count zero
    logic        cond;      // selected condition
    logic        pass;      // test result
    logic        is_cmp;    // compare instruction
    logic        is_br;     // conditional branch family
    sq_pkg::sq_na_type na;  // next address choice

    // ==========================================================
    // combinational decode and next state
    always_comb begin
        next_st   = st;
        mem_we    = 1'b0;
        op        = st.pipe[sq_pkg::OP_MSB -: 5];
        condition_polarity       = st.pipe[sq_pkg::POL_BIT];
        sel       = st.pipe[sq_pkg::TEST_MSB -: 4];
        data      = st.pipe[sq_pkg::DATA_MSB -: 9];
        // per-pin choice of registered or filtered input
        tst       = (st.tsync & st.t_r) | (~st.tsync & st.t_f);
        rst_act   = st.rsync ? ~st.r_r : ~st.r_f;
        tm        = tst & data[7:0];
        bv_tm     = {data[8], tm};
        stack_top = st.stack[sq_dec17(st.sp)];
        zero      = (st.count_register == 9'h000);
        // sixteen way select, always-conditions read as zero
        if (sel < sq_pkg::SEL_MATCH) begin
            cond = tst[sel[2:0]];
        end else if (sel == sq_pkg::SEL_MATCH) begin
            cond = st.match;
        end else if (sel == sq_pkg::SEL_ZERO) begin
            cond = zero;
        end else begin
            cond = 1'b0;
        end
        pass   = cond ^ condition_polarity;
        is_cmp = (op[4:2] == sq_pkg::OP_CMP_TOP);
        is_br  = 1'b0;
        na     = sq_pkg::NA_INC;
        // instruction decoder, masked values ignore polarity
        if (st.run) begin
            unique case (1'b1)
                is_cmp: begin
                    // a match sets, a mismatch keeps the flag
                    if (tm == st.pipe[sq_pkg::CONST_MSB -: 8]) begin
                        next_st.match = 1'b1;
                    end
                end
                (op == sq_pkg::OP_GOPL): begin
                    is_br = 1'b1;
                    na    = pass ? sq_pkg::NA_BR : sq_pkg::NA_INC;
                end
                (op == sq_pkg::OP_GOTM): begin
                    is_br = 1'b1;
                    na    = pass ? sq_pkg::NA_BR : sq_pkg::NA_INC;
                end
                (op == sq_pkg::OP_GOSTK): begin
                    is_br = 1'b1;
                    na    = pass ? sq_pkg::NA_TOP : sq_pkg::NA_INC;
                end
                (op == sq_pkg::OP_FORK): begin
                    is_br = 1'b1;
                    na    = pass ? sq_pkg::NA_BR : sq_pkg::NA_TOP;
                end
                (op == sq_pkg::OP_CALPL || op == sq_pkg::OP_CALTM): begin
                    is_br = 1'b1;
                    if (pass) begin
                        // stack source: incremented pc
                        na = sq_pkg::NA_BR;
                        next_st.stack[st.sp] = st.pc + 9'h001;
                        next_st.sp = sq_inc17(st.sp);
                    end
                end
                (op == sq_pkg::OP_RET || op == sq_pkg::OP_RETPL): begin
                    if (pass) begin
                        na         = sq_pkg::NA_TOP;
                        next_st.sp = sq_dec17(st.sp);
                        if (op == sq_pkg::OP_RETPL) begin
                            next_st.count_register = data;
                        end
                    end
                end
                (op == sq_pkg::OP_PSHCNT): begin
                    // stack source: count register
                    next_st.stack[st.sp] = st.count_register;
                    next_st.sp = sq_inc17(st.sp);
                end
                (op == sq_pkg::OP_POPCNT): begin
                    next_st.count_register = stack_top;
                    next_st.sp   = sq_dec17(st.sp);
                end
                (op == sq_pkg::OP_LDPL): begin
                    next_st.count_register = data;
                end
                (op == sq_pkg::OP_LDTM): begin
                    next_st.count_register = bv_tm;
                end
                (op == sq_pkg::OP_LOOP): begin
                    // branch back and count down until zero
                    if (!zero) begin
                        na           = sq_pkg::NA_BR;
                        next_st.count_register = st.count_register - 9'h001;
                    end
                end
                (op == sq_pkg::OP_WAIT): begin
                    na = pass ? sq_pkg::NA_INC : sq_pkg::NA_PC;
                end
                default: begin
                    na = sq_pkg::NA_INC;
                end
            endcase
            // branches testing the match flag clear it
            if (is_br && sel == sq_pkg::SEL_MATCH) begin
                next_st.match = 1'b0;
            end
        end else begin
            na = sq_pkg::NA_PC;
        end
        // four-way next address mux
        unique case (na)
            sq_pkg::NA_PC:  next_addr = st.pc;
            sq_pkg::NA_INC: next_addr = st.pc + 9'h001;
            sq_pkg::NA_BR:  next_addr = (op == sq_pkg::OP_GOTM ||
                                        op == sq_pkg::OP_CALTM) ? bv_tm : data;
            sq_pkg::NA_TOP: next_addr = stack_top;
            default: next_addr = st.pc;
        endcase
        // sequencer reset wins over any instruction
        if (rst_act) begin
            next_addr     = sq_pkg::RESET_ADDR;
            next_st.match = 1'b0;
            next_st.count_register  = st.count_register;
            next_st.sp    = st.sp;
            next_st.stack = st.stack;
        end
        mem_word = prog_mem[next_addr];
        if (st.run || rst_act) begin
            next_st.pc   = next_addr;
            next_st.pipe = mem_word;
            next_st.ctl_out   = mem_word[15:0];
            next_st.ctl_hi_oe = mem_word[sq_pkg::OE_BIT];
            if (st.run && op == sq_pkg::OP_OUTPUT && !rst_act) begin
                next_st.ctl_out[15:8] = st.count_register[7:0];
                next_st.ctl_out[1]    = st.count_register[8];
            end else if (st.expose) begin
                next_st.ctl_out[15:8] = next_addr[7:0];
                next_st.ctl_out[1]    = next_addr[8];
            end
        end
        // pin synchronisers, a change counts once stages agree
        next_st.t_s1 = test_in;
        next_st.t_s2 = st.t_s1;
        next_st.t_s3 = st.t_s2;
        next_st.t_f  = (st.t_s2 & st.t_s3) | (st.t_f & (st.t_s2 ^ st.t_s3));
        next_st.t_r  = st.t_f;
        next_st.r_s1 = seq_rst_n;
        next_st.r_s2 = st.r_s1;
        next_st.r_s3 = st.r_s2;
        next_st.r_f  = (st.r_s2 == st.r_s3) ? st.r_s3 : st.r_f;
        next_st.r_r  = st.r_f;
        // apb: ready in the first access cycle, data set up before
        next_st.pready  = psel & ~penable;
        next_st.prdata  = 32'h0000_0000;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            unique case (paddr)
                sq_pkg::CTRL_OFS: begin
                    next_st.prdata[sq_pkg::CTRL_RUN_BIT]    = st.run;
                    next_st.prdata[sq_pkg::CTRL_EXPOSE_BIT] = st.expose;
                    next_st.prdata[sq_pkg::CTRL_RSYNC_BIT]  = st.rsync;
                    next_st.prdata[sq_pkg::CTRL_TSYNC_LSB +: 8] = st.tsync;
                end
                sq_pkg::MEM_ADDR_OFS: next_st.prdata[8:0] = st.mem_addr;
                sq_pkg::MEM_LO_OFS:   next_st.prdata = st.mem_lo;
                sq_pkg::MEM_HI_OFS:   next_st.prdata = 32'h0000_0000;
                sq_pkg::STATUS_OFS: begin
                    next_st.prdata[sq_pkg::ST_PC_LSB +: 9]   = st.pc;
                    next_st.prdata[sq_pkg::ST_MATCH]         = st.match;
                    next_st.prdata[sq_pkg::ST_ZERO]          = zero;
                    next_st.prdata[sq_pkg::ST_SP_LSB +: 5]   = st.sp;
                    next_st.prdata[sq_pkg::ST_COUNT_REGISTER_LSB +: 9] = st.count_register;
                end
                default: next_st.pslverr = 1'b1;
            endcase
        end else begin
            next_st.prdata  = st.prdata;
            next_st.pslverr = st.pslverr & psel;
        end
        // writes take effect at the completing edge
        if (psel && penable && st.pready && pwrite) begin
            unique case (paddr)
                sq_pkg::CTRL_OFS: begin
                    next_st.run    = pwdata[sq_pkg::CTRL_RUN_BIT];
                    next_st.expose = pwdata[sq_pkg::CTRL_EXPOSE_BIT];
                    next_st.rsync  = pwdata[sq_pkg::CTRL_RSYNC_BIT];
                    next_st.tsync  = pwdata[sq_pkg::CTRL_TSYNC_LSB +: 8];
                end
                sq_pkg::MEM_ADDR_OFS: next_st.mem_addr = pwdata[8:0];
                sq_pkg::MEM_LO_OFS:   next_st.mem_lo = pwdata;
                sq_pkg::MEM_HI_OFS: begin
                    mem_we           = 1'b1;
                    next_st.mem_addr = st.mem_addr + 9'h001;
                end
                default: mem_we = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st       <= '0;
            st.pc    <= sq_pkg::RESET_ADDR;
            st.r_s1  <= 1'b1;
            st.r_s2  <= 1'b1;
            st.r_s3  <= 1'b1;
            st.r_f   <= 1'b1;
            st.r_r   <= 1'b1;
            st.run   <= sq_pkg::RUN_RST;
            st.expose <= sq_pkg::EXP_RST;
            st.rsync <= sq_pkg::RSYNC_RST;
            st.tsync <= sq_pkg::TSYNC_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // program memory load port
    always_ff @(posedge pclk) begin
        if (ce && mem_we) begin
            prog_mem[st.mem_addr] <= {pwdata[3:0], st.mem_lo};
        end
    end

    // outputs straight from the state register
    assign prdata    = st.prdata;
    assign pready    = st.pready;
    assign pslverr   = st.pslverr;
    assign ctl_out   = st.ctl_out;
    assign ctl_hi_oe = st.ctl_hi_oe;

    // ==========================================================
    // checks
    default clocking sq_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic step; // an instruction executes this edge
    assign step = ce && st.run && !rst_act;

    reset_addr_a: assert property (ce && rst_act |=>
        st.pc == sq_pkg::RESET_ADDR && !st.match)
        else $error("reset did not load address 511");
    push_ptr_a: assert property (step && op == sq_pkg::OP_PSHCNT
        |=> st.sp == sq_inc17($past(st.sp)) && stack_top == $past(st.count_register))
        else $error("count push wrong");
    pop_ptr_a: assert property (step && op == sq_pkg::OP_POPCNT |=>
        st.sp == sq_dec17($past(st.sp)) && st.count_register == $past(stack_top))
        else $error("count pop wrong");
    cmp_set_a: assert property (step && is_cmp &&
        tm == st.pipe[sq_pkg::CONST_MSB -: 8] |=> st.match)
        else $error("compare match did not set flag");
    cmp_keep_a: assert property (step && is_cmp &&
        tm != st.pipe[sq_pkg::CONST_MSB -: 8] |=> $stable(st.match))
        else $error("compare mismatch changed flag");
    br_clear_a: assert property (step && is_br &&
        sel == sq_pkg::SEL_MATCH |=> !st.match)
        else $error("branch on match left flag set");
    always_pass_a: assert property (step && op == sq_pkg::OP_GOPL &&
        sel > sq_pkg::SEL_ZERO |=> st.pc == ($past(condition_polarity) ? $past(data)
        : $past(st.pc) + 9'h001))
        else $error("always-condition ignored polarity");
    output_cnt_a: assert property (step && op == sq_pkg::OP_OUTPUT
        |=> {ctl_out[1], ctl_out[15:8]} == $past(st.count_register))
        else $error("count not shown on outputs");
    expose_a: assert property (step && st.expose &&
        op != sq_pkg::OP_OUTPUT |=> ctl_out[15:8] == st.pc[7:0])
        else $error("next address not exposed");

endmodule : sq_sequencer

/* File: inc/sq_pkg.sv */
// constants shared by the microprogram address sequencer
// assumes a single pclk domain and an apb master on the register side
package sq_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] CTRL_OFS     = 8'h00; // run, options
    localparam logic [7:0] MEM_ADDR_OFS = 8'h04; // program load address
    localparam logic [7:0] MEM_LO_OFS   = 8'h08; // word bits 31:0
    localparam logic [7:0] MEM_HI_OFS   = 8'h0C; // word bits 35:32, commits
    localparam logic [7:0] STATUS_OFS   = 8'h10; // sequencer state

    // ==========================================================
    // control register fields
    localparam int CTRL_RUN_BIT    = 0;  // sequencer steps while set
    localparam int CTRL_EXPOSE_BIT = 1;  // address_expose_option
    localparam int CTRL_RSYNC_BIT  = 2;  // reset pin synchronised
    localparam int CTRL_TSYNC_LSB  = 8;  // test pin sync bits 15:8
    localparam logic       RUN_RST   = 1'b0;  // stopped after reset
    localparam logic       EXP_RST   = 1'b0;  // address not exposed
    localparam logic       RSYNC_RST = 1'b1;  // unprogrammed: synced
    localparam logic [7:0] TSYNC_RST = 8'hFF; // unprogrammed: synced

    // ==========================================================
    // status register fields
    localparam int ST_PC_LSB   = 0;  // program counter 8:0
    localparam int ST_MATCH    = 9;  // match flag
    localparam int ST_ZERO     = 10; // count zero
    localparam int ST_SP_LSB   = 11; // stack pointer 15:11
    localparam int ST_COUNT_REGISTER_LSB = 16; // count register 24:16

    // ==========================================================
    // microword fields
    localparam int OE_BIT    = 35; // upper outputs enable
    localparam int OP_MSB    = 34; // opcode 34:30
    localparam int POL_BIT   = 29; // condition_polarity
    localparam int TEST_MSB  = 28; // condition select 28:25
    localparam int DATA_MSB  = 24; // data 24:16
    localparam int CONST_MSB = 31; // compare constant 31:24
    localparam int MASK_MSB  = 23; // compare mask 23:16

    // ==========================================================
    // condition select codes and sizes
    localparam logic [3:0] SEL_MATCH = 4'h8; // match_flag
    localparam logic [3:0] SEL_ZERO  = 4'h9; // count zero
    localparam logic [8:0] RESET_ADDR  = 9'h1FF; // word 511
    localparam logic [4:0] STACK_LAST  = 5'h10;  // 17 entries, 0..16

    // ==========================================================
    // opcodes
    localparam logic [4:0] OP_RETPL   = 5'h00; // return, load count
    localparam logic [4:0] OP_CONT    = 5'h01; // continue
    localparam logic [4:0] OP_RET     = 5'h02; // conditional return
    localparam logic [4:0] OP_GOSTK   = 5'h03; // branch to stack_top
    localparam logic [4:0] OP_PSHCNT  = 5'h04; // push_count_instruction
    localparam logic [4:0] OP_POPCNT  = 5'h05; // pop_count_instruction
    localparam logic [4:0] OP_LDPL    = 5'h06; // load count from data
    localparam logic [4:0] OP_LDTM    = 5'h07; // load count masked
    localparam logic [4:0] OP_LOOP    = 5'h08; // count down to zero, branch to data
    localparam logic [4:0] OP_OUTPUT  = 5'h09; // count to outputs
    localparam logic [4:0] OP_WAIT    = 5'h0A; // hold until pass
    localparam logic [2:0] OP_CMP_TOP = 3'b100; // compare, 10000..10011
    localparam logic [4:0] OP_FORK    = 5'h18; // data or stack_top
    localparam logic [4:0] OP_GOPL    = 5'h19; // branch to data
    localparam logic [4:0] OP_GOTM    = 5'h1A; // branch masked
    localparam logic [4:0] OP_CALPL   = 5'h1C; // call data
    localparam logic [4:0] OP_CALTM   = 5'h1E; // call masked

    // next address choice
    typedef enum logic [3:0] {
        NA_PC  = 4'b0001,
        NA_INC = 4'b0010,
        NA_BR  = 4'b0100,
        NA_TOP = 4'b1000
    } sq_na_type;

endpackage : sq_pkg

/* File: bench/sq_ext_logic.sv */
// far side model: system logic that drives the sequencer test pins
// assumes the bench hands it the next value and a shared pclk
module sq_ext_logic (
    input  wire logic       pclk,    // system clock
    input  wire logic [7:0] req,     // value the system wants to show
    output logic      [7:0] test_in  // test pins of the sequencer
);
    timeunit 1ns;
    timeprecision 1ps;
    // value is launched an edge ahead of the cycle that uses it
    always_ff @(posedge pclk) begin
        test_in <= req;
    end
endmodule : sq_ext_logic

/* File: bench/tb_top.sv */
// self-checking bench for the sequencer, driven over apb
// assumes sq_sequencer and sq_pkg are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        seq_rst_n, ctl_hi_oe, e;
    logic [7:0]  paddr, req, test_in;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] ctl_out;
    int          num_errors, n_checks;
    sq_ext_logic ext (.pclk(pclk), .req(req), .test_in(test_in));
    sq_sequencer dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .test_in(test_in), .seq_rst_n(seq_rst_n),
        .ctl_out(ctl_out), .ctl_hi_oe(ctl_hi_oe));
    // ==========================================================
    // shared tasks
    task chk(input logic [35:0] s, input logic [35:0] x);
        n_checks++;
        if (s !== x) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite} <= {2'b10, w};
        {paddr, pwdata} <= {a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // program word goes low half first, high half commits
    task ld(input logic [8:0] a, input logic [35:0] w);
        apb(1'b1, sq_pkg::MEM_ADDR_OFS, {23'h0, a});
        apb(1'b1, sq_pkg::MEM_LO_OFS, w[31:0]);
        apb(1'b1, sq_pkg::MEM_HI_OFS, {28'h0, w[35:32]});
    endtask : ld
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // ==========================================================
    // scenarios
    task t_regs;
        apb(1'b0, sq_pkg::CTRL_OFS, 32'h0);
        chk(r, 36'h0000FF04);
        apb(1'b0, 8'h20, 32'h0);
        chk({e, r}, 36'h100000000);
        $display("test regs done");
    endtask : t_regs
    // reset to 511, branch to 5, compare sets match, park at 6
    task t_run;
        ld(9'h1FF, {1'b1, 5'h19, 1'b1, 4'hA, 9'h005, 16'h0000});
        ld(9'h005, {1'b1, 3'b100, 8'h5A, 8'hFF, 16'hC3C3});
        ld(9'h006, {1'b0, 5'h19, 1'b1, 4'hA, 9'h006, 16'h0081});
        req <= 8'h5A;
        seq_rst_n <= 1'b0;
        repeat (8) @(posedge pclk);
        seq_rst_n <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, sq_pkg::STATUS_OFS, 32'h0);
        chk(r[9:0], 36'h1FF);
        apb(1'b1, sq_pkg::CTRL_OFS, 32'h0000FF05);
        repeat (4) @(posedge pclk);
        chk({ctl_hi_oe, ctl_out}, 36'h00081);
        apb(1'b0, sq_pkg::STATUS_OFS, 32'h0);
        chk(r[9:0], 36'h206);
        apb(1'b1, sq_pkg::CTRL_OFS, 32'h0000FF07);
        repeat (4) @(posedge pclk);
        chk(ctl_out, 36'h0681);
        $display("test run done");
    endtask : t_run
    // stack, loop, call, return, match clear, masked values, unsynced pins
    task t_loop;
        apb(1'b1, sq_pkg::CTRL_OFS, 32'h0);
        ld(9'h1FF, {1'b0, 5'h19, 1'b1, 4'hA, 9'h020, 16'h0}); // go to 0x20
        ld(9'h020, {1'b0, 5'h06, 1'b0, 4'h0, 9'h003, 16'h0}); // count 3
        ld(9'h021, {1'b0, 5'h04, 1'b0, 4'h0, 9'h000, 16'h0}); // push count
        ld(9'h022, {1'b0, 5'h06, 1'b0, 4'h0, 9'h002, 16'h0}); // count 2
        ld(9'h023, {1'b0, 5'h08, 1'b0, 4'h0, 9'h023, 16'h0}); // loop to zero
        ld(9'h024, {1'b0, 5'h05, 1'b0, 4'h0, 9'h000, 16'h0}); // pop count
        ld(9'h025, {1'b0, 5'h1C, 1'b1, 4'hA, 9'h030, 16'h0}); // call 0x30
        ld(9'h030, {1'b0, 5'h09, 1'b0, 4'h0, 9'h000, 16'h0}); // show count
        ld(9'h031, {1'b0, 5'h02, 1'b1, 4'hA, 9'h000, 16'h0}); // return
        ld(9'h026, {1'b0, 3'b100, 8'h00, 8'hFF, 16'h0});      // no match
        ld(9'h027, {1'b0, 3'b100, 8'h5A, 8'hFF, 16'h0});      // match
        ld(9'h028, {1'b0, 5'h19, 1'b0, 4'h8, 9'h02A, 16'h0}); // on match
        ld(9'h02A, {1'b0, 5'h1A, 1'b1, 4'hA, 9'h00F, 16'h0}); // masked 0x0A
        ld(9'h00A, {1'b0, 5'h07, 1'b0, 4'h0, 9'h1F0, 16'h0}); // count 0x150
        ld(9'h00B, {1'b0, 5'h19, 1'b1, 4'hA, 9'h00B, 16'h0}); // park
        seq_rst_n <= 1'b0;
        repeat (6) @(posedge pclk);
        seq_rst_n <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, sq_pkg::STATUS_OFS, 32'h0);
        chk(r[9:0], 36'h1FF);
        apb(1'b1, sq_pkg::CTRL_OFS, 32'h1);
        repeat (40) @(posedge pclk);
        apb(1'b0, sq_pkg::STATUS_OFS, 32'h0);
        chk(r[24:0], 36'h0150000B);
        $display("test loop done");
    endtask : t_loop
    // ==========================================================
    // clock, reset, sequence and watchdog
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {seq_rst_n, req, num_errors, n_checks} = {1'b1, 8'h00, 64'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_run();
        t_loop();
        conclude();
    end
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule : tb_top
